// File: hw/cfr_follower.sv
// Follower receive engine for a single-wire control bus with APB registers
//
// The address map and register access over APB were left to the implementer.
`timescale 1ns/1ps
`include "cfr_defines.svh"

// Functional notes
// - Start accepted only if low until low duty, then released before uncertainty and no fall until period.
// - Valid start sets the start-detected flag.
// - Start flag raises interrupt only with its enable set.
// - Role bit clear means receiver; set means transmitter, receiver then idle.
// - After nine bits, drive acknowledge, then raise receive interrupt.
// - Each bit sampled at sample-point count after latest falling edge.
// - Acknowledge timed by the bit-period count.
// - Acknowledge value 0 holds bus low for zero low duty.
// - First eight bits stored in readable received byte register.
// - Ninth bit kept as readable end-of-message indicator.
// - Receive-done flag set after nine bits and acknowledge sent.
// - Receive flag raises interrupt only with its enable set.
// - After start, edges closer than minimum spacing set line-fault flag.
// - After start and an edge, missing next edge by limit sets timeout flag.
// - No timeout check while waiting for the tenth edge.
// - Line-fault flag raises interrupt only with its enable set.
// - Timeout flag raises interrupt only with its enable set.
// - Both wake enables plus low bus restart oscillator and leave STOP.
// - All timing values count engine clock periods.
// - Acknowledge occupies the tenth bit position after data and end bit.
module cfr_follower (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cec_in,
  output logic             cec_out,
  output logic             cec_oe,
  input  wire logic        stop_mode,
  output logic             osc_wake,
  output logic             irq
);
  import cfr_pkg::*;

  cfr_ctrl_s  ctrl_q;
  cfr_flags_s flags_q, flag_set, flag_clr;
  cfr_state_e state_q;
  logic [7:0] st_prd_q, st_low_q, st_unc_q, sample_q, bit_prd_q;
  logic [7:0] zero_low_q, one_low_q, min_sp_q, tmout_q;
  logic [7:0] rx_byte_q, div_q;
  logic       rx_eom_q, sync1_q, sync2_q, prev_q, sampled_q, edge_seen_q;
  logic [8:0] shift_q, cnt_q;
  logic [3:0] bit_idx_q;
  logic       tick, fall, line_high, wr_en, rd_take, mapped;
  logic [7:0] ack_duty;
  logic [31:0] rd_data;
  logic       prdy_q, perr_q, oe_q, wake_q, irq_q;
  logic [31:0] prdata_q;

  // Two-stage synchroniser for the bus pin, then edge history
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
      prev_q  <= 1'b1;
    end else begin
      sync1_q <= cec_in;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end
  assign line_high = sync2_q;
  assign fall      = prev_q & ~sync2_q;

  // Engine clock prescaler
  always_ff @(posedge ref_clk) begin
    if (rst || tick) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end
  assign tick = (div_q == (`CFR_ENG_DIV - 8'h01));

  // Engine periods since the latest falling edge, saturating
  always_ff @(posedge ref_clk) begin
    if (rst || fall) begin
      cnt_q <= 9'h000;
    end else if (tick && cnt_q != `CFR_CNT_MAX) begin
      cnt_q <= cnt_q + 9'h001;
    end
  end

  assign ack_duty = ctrl_q.ack_value ? one_low_q : zero_low_q;

  // Receive sequencer
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q     <= ST_IDLE;
      shift_q     <= 9'h000;
      bit_idx_q   <= 4'h0;
      sampled_q   <= 1'b1;
      edge_seen_q <= 1'b0;
      rx_byte_q   <= 8'h00;
      rx_eom_q    <= 1'b0;
      flag_set    <= '0;
    end else begin
      flag_set <= '0;
      case (state_q)
        ST_IDLE: begin
          if (fall && !ctrl_q.transmit_role_select) begin
            state_q <= ST_SLOW;
          end
        end
        ST_SLOW: begin
          if (line_high && cnt_q < {1'b0, st_low_q}) begin
            state_q <= ST_IDLE;
          end else if (cnt_q >= {1'b0, st_low_q}) begin
            state_q <= ST_SHIGH;
          end
        end
        ST_SHIGH: begin
          if (cnt_q >= {1'b0, st_prd_q}) begin
            state_q                      <= ST_BITS;
            flag_set.start_detected_flag <= 1'b1;
            bit_idx_q                    <= 4'h0;
            sampled_q                    <= 1'b1;
            edge_seen_q                  <= 1'b0;
          end else if (fall || (!line_high && cnt_q >= {1'b0, st_unc_q})) begin
            state_q <= ST_IDLE;
          end
        end
        ST_BITS, ST_ACKW, ST_ACKD: begin
          if (fall && edge_seen_q && cnt_q < {1'b0, min_sp_q}) begin
            flag_set.line_fault_flag <= 1'b1;
            state_q                  <= ST_IDLE;
          end else if (state_q == ST_BITS && edge_seen_q && !fall
                       && cnt_q > {1'b0, tmout_q}) begin
            flag_set.edge_timeout_flag <= 1'b1;
            state_q                    <= ST_IDLE;
          end else begin
            if (fall) begin
              edge_seen_q <= 1'b1;
            end
            case (state_q)
              ST_BITS: begin
                if (fall) begin
                  sampled_q <= 1'b0;
                end else if (!sampled_q && cnt_q == {1'b0, sample_q}) begin
                  sampled_q <= 1'b1;
                  shift_q   <= {shift_q[7:0], line_high};
                  bit_idx_q <= bit_idx_q + 4'h1;
                  if (bit_idx_q == 4'h8) begin
                    state_q <= ST_ACKW;
                  end
                end
              end
              ST_ACKW: begin
                if (fall) begin
                  state_q <= ST_ACKD;
                end
              end
              default: begin
                if (cnt_q >= {1'b0, bit_prd_q}) begin
                  rx_byte_q                  <= shift_q[8:1];
                  rx_eom_q                   <= shift_q[0];
                  flag_set.receive_done_flag <= 1'b1;
                  bit_idx_q                  <= 4'h0;
                  sampled_q                  <= 1'b1;
                  state_q                    <= shift_q[0] ? ST_IDLE : ST_BITS;
                end
              end
            endcase
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Acknowledge drive: bus pulled low for the selected duty only
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= (state_q == ST_ACKD) && (cnt_q < {1'b0, ack_duty});
    end
  end

  // Wake request while stopped and the bus is held low
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= ctrl_q.pad_wake_enable && ctrl_q.bus_wake_enable
                && stop_mode && !line_high;
    end
  end

  // Sticky flags, set wins over a write-one clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flags_q <= '0;
    end else begin
      flags_q <= flag_set | (flags_q & ~flag_clr);
    end
  end

  // Interrupt request from enabled flags
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= (flags_q.start_detected_flag && ctrl_q.start_irq_enable)
            || (flags_q.receive_done_flag && ctrl_q.receive_irq_enable)
            || (flags_q.line_fault_flag && ctrl_q.line_fault_irq_enable)
            || (flags_q.edge_timeout_flag && ctrl_q.edge_timeout_irq_enable);
    end
  end

  // APB decode
  assign wr_en   = psel && penable && prdy_q && pwrite;
  assign rd_take = psel && !penable;
  assign flag_clr = wr_en && paddr == `CFR_OFS_STATUS ? pwdata[3:0] : 4'h0;

  always_comb begin
    mapped  = 1'b1;
    rd_data = 32'h0000_0000;
    case (paddr)
      `CFR_OFS_CTRL:   rd_data[7:0] = ctrl_q;
      `CFR_OFS_STATUS: rd_data[3:0] = flags_q;
      `CFR_OFS_RXDATA: rd_data[8:0] = {rx_eom_q, rx_byte_q};
      `CFR_OFS_STPRD:  rd_data[7:0] = st_prd_q;
      `CFR_OFS_STLOW:  rd_data[7:0] = st_low_q;
      `CFR_OFS_STUNC:  rd_data[7:0] = st_unc_q;
      `CFR_OFS_SAMPLE: rd_data[7:0] = sample_q;
      `CFR_OFS_BITPRD: rd_data[7:0] = bit_prd_q;
      `CFR_OFS_ZLOW:   rd_data[7:0] = zero_low_q;
      `CFR_OFS_OLOW:   rd_data[7:0] = one_low_q;
      `CFR_OFS_MINSP:  rd_data[7:0] = min_sp_q;
      `CFR_OFS_TMOUT:  rd_data[7:0] = tmout_q;
      default:         mapped       = 1'b0;
    endcase
  end

  // Bus answer: ready in the first access cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prdy_q   <= 1'b0;
      perr_q   <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      prdy_q   <= rd_take;
      perr_q   <= rd_take && !mapped;
      prdata_q <= (rd_take && !pwrite) ? rd_data : 32'h0000_0000;
    end
  end

  // Software-written registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_q     <= `CFR_RST_CTRL;
      st_prd_q   <= `CFR_RST_STPRD;
      st_low_q   <= `CFR_RST_STLOW;
      st_unc_q   <= `CFR_RST_STUNC;
      sample_q   <= `CFR_RST_SAMPLE;
      bit_prd_q  <= `CFR_RST_BITPRD;
      zero_low_q <= `CFR_RST_ZLOW;
      one_low_q  <= `CFR_RST_OLOW;
      min_sp_q   <= `CFR_RST_MINSP;
      tmout_q    <= `CFR_RST_TMOUT;
    end else if (wr_en) begin
      case (paddr)
        `CFR_OFS_CTRL:   ctrl_q     <= pwdata[7:0];
        `CFR_OFS_STPRD:  st_prd_q   <= pwdata[7:0];
        `CFR_OFS_STLOW:  st_low_q   <= pwdata[7:0];
        `CFR_OFS_STUNC:  st_unc_q   <= pwdata[7:0];
        `CFR_OFS_SAMPLE: sample_q   <= pwdata[7:0];
        `CFR_OFS_BITPRD: bit_prd_q  <= pwdata[7:0];
        `CFR_OFS_ZLOW:   zero_low_q <= pwdata[7:0];
        `CFR_OFS_OLOW:   one_low_q  <= pwdata[7:0];
        `CFR_OFS_MINSP:  min_sp_q   <= pwdata[7:0];
        `CFR_OFS_TMOUT:  tmout_q    <= pwdata[7:0];
        default: begin
        end
      endcase
    end
  end

  // Pin drive: open drain, only ever pulls low
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cec_out <= 1'b0;
    end else begin
      cec_out <= 1'b0;
    end
  end

  assign prdata   = prdata_q;
  assign pready   = prdy_q;
  assign pslverr  = perr_q;
  assign cec_oe   = oe_q;
  assign osc_wake = wake_q;
  assign irq      = irq_q;

  // Checks
  a_start_flag_set: assert property (@(posedge ref_clk) disable iff (rst)
    state_q == ST_SHIGH && cnt_q >= {1'b0, st_prd_q} |-> ##2 flags_q.start_detected_flag)
    else $error("start flag not set after valid start");
  a_start_abort_low: assert property (@(posedge ref_clk) disable iff (rst)
    state_q == ST_SLOW && line_high && cnt_q < {1'b0, st_low_q} |=> state_q == ST_IDLE)
    else $error("short start low not rejected");
  a_role_blocks_rx: assert property (@(posedge ref_clk) disable iff (rst)
    state_q == ST_IDLE && ctrl_q.transmit_role_select |=> state_q == ST_IDLE)
    else $error("receiver left idle in transmit role");
  a_ack_drive_low: assert property (@(posedge ref_clk) disable iff (rst)
    state_q == ST_ACKD && cnt_q < {1'b0, ack_duty} |=> cec_oe)
    else $error("acknowledge not driven low");
  a_rx_done_flag: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(flags_q.receive_done_flag) |-> $past(state_q, 2) == ST_ACKD)
    else $error("receive flag set outside acknowledge");
  a_line_fault: assert property (@(posedge ref_clk) disable iff (rst)
    state_q == ST_BITS && fall && edge_seen_q && cnt_q < {1'b0, min_sp_q}
    |=> state_q == ST_IDLE ##1 flags_q.line_fault_flag)
    else $error("close edges not flagged");
  a_no_tmout_ackw: assert property (@(posedge ref_clk) disable iff (rst)
    state_q == ST_ACKW && !fall |=> state_q == ST_ACKW && !flag_set.edge_timeout_flag)
    else $error("timeout raised while waiting for tenth edge");
  a_irq_follows: assert property (@(posedge ref_clk) disable iff (rst)
    flags_q.receive_done_flag && ctrl_q.receive_irq_enable
    && $stable(flags_q.receive_done_flag) |=> irq)
    else $error("interrupt missing for enabled flag");
  a_wake_req: assert property (@(posedge ref_clk) disable iff (rst)
    osc_wake |-> $past(ctrl_q.pad_wake_enable) && $past(ctrl_q.bus_wake_enable))
    else $error("wake without both enables");
endmodule

// File: include/cfr_defines.svh
// Register offsets, field positions, reset values and timing constants
`ifndef CFR_DEFINES_SVH
`define CFR_DEFINES_SVH
`define CFR_OFS_CTRL      12'h000
`define CFR_OFS_STATUS    12'h004
`define CFR_OFS_RXDATA    12'h008
`define CFR_OFS_STPRD     12'h00C
`define CFR_OFS_STLOW     12'h010
`define CFR_OFS_STUNC     12'h014
`define CFR_OFS_SAMPLE    12'h018
`define CFR_OFS_BITPRD    12'h01C
`define CFR_OFS_ZLOW      12'h020
`define CFR_OFS_OLOW      12'h024
`define CFR_OFS_MINSP     12'h028
`define CFR_OFS_TMOUT     12'h02C
`define CFR_FLG_START     0
`define CFR_FLG_RXDONE    1
`define CFR_FLG_LFAULT    2
`define CFR_FLG_TMOUT     3
`define CFR_RST_CTRL      8'h00
`define CFR_RST_STPRD     8'hB4
`define CFR_RST_STLOW     8'h94
`define CFR_RST_STUNC     8'hA0
`define CFR_RST_SAMPLE    8'h39
`define CFR_RST_BITPRD    8'h78
`define CFR_RST_ZLOW      8'h5A
`define CFR_RST_OLOW      8'h18
`define CFR_RST_MINSP     8'h10
`define CFR_RST_TMOUT     8'hC8
`define CFR_ENG_DIV       8'h04
`define CFR_CNT_MAX       9'h1FF
`endif

// File: include/cfr_pkg.sv
// Types shared by the follower receiver
package cfr_pkg;
  typedef struct packed {
    logic bus_wake_enable;
    logic pad_wake_enable;
    logic edge_timeout_irq_enable;
    logic line_fault_irq_enable;
    logic receive_irq_enable;
    logic start_irq_enable;
    logic ack_value;
    logic transmit_role_select;
  } cfr_ctrl_s;
  typedef struct packed {
    logic edge_timeout_flag;
    logic line_fault_flag;
    logic receive_done_flag;
    logic start_detected_flag;
  } cfr_flags_s;
  typedef enum logic [2:0] {
    ST_IDLE, ST_SLOW, ST_SHIGH, ST_BITS, ST_ACKW, ST_ACKD
  } cfr_state_e;
endpackage

// File: verif/cfr_initiator.sv
// Initiator model that drives the shared bus toward the follower
`timescale 1ns/1ps
module cfr_initiator (
  input  wire logic ref_clk,
  input  wire logic line,
  output logic      drv_low
);
  logic seen;
  initial drv_low = 1'b0;
  // Waits a number of engine periods of four clocks
  task automatic wait_e(input int n);
    repeat (4 * n) @(posedge ref_clk);
  endtask
  // Pulls low for a while, then releases to the pull-up
  task automatic slot(input int low, input int len);
    drv_low <= 1'b1;
    wait_e(low);
    drv_low <= 1'b0;
    wait_e(len - low);
  endtask
  // Start shape, released before the uncertainty point
  task automatic start();
    slot(150, 192);
  endtask
  // One bit, a one uses the short low duty
  task automatic send_bit(input logic b);
    slot(b ? 24 : 90, 120);
  endtask
  // Eight data bits, end flag, optional idle gap, then the acknowledge slot
  task automatic send_byte(input logic [7:0] d, input logic eom, input int gap);
    for (int i = 7; i >= 0; i--) begin
      send_bit(d[i]);
    end
    send_bit(eom);
    wait_e(gap);
    drv_low <= 1'b1;
    wait_e(24);
    drv_low <= 1'b0;
    wait_e(33);
    seen = line;
    wait_e(63);
  endtask
endmodule

// File: verif/cfr_follower_tb.sv
// Self-checking bench for the follower receiver
`timescale 1ns/1ps
`include "cfr_defines.svh"
module cfr_follower_tb;
  import cfr_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rst     = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0;
  logic        stop_mode = 1'b0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        pslverr;
  logic        slv;
  logic        cec_out;
  logic        cec_oe;
  logic        osc_wake;
  logic        irq;
  logic        drv_low;
  logic        line;
  int          num_errors = 0;
  int          cmp_count  = 0;
  logic [7:0]  rstv [9] = '{`CFR_RST_STPRD, `CFR_RST_STLOW, `CFR_RST_STUNC,
    `CFR_RST_SAMPLE, `CFR_RST_BITPRD, `CFR_RST_ZLOW, `CFR_RST_OLOW,
    `CFR_RST_MINSP, `CFR_RST_TMOUT};
  // Open-drain bus with pull-up
  assign line = ~(drv_low | cec_oe);
  always #4 ref_clk = ~ref_clk;
  cfr_follower cfr_follower_inst (.ref_clk(ref_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cec_in(line),
    .cec_out(cec_out), .cec_oe(cec_oe), .stop_mode(stop_mode),
    .osc_wake(osc_wake), .irq(irq));
  cfr_initiator cfr_initiator_inst (.ref_clk(ref_clk), .line(line), .drv_low(drv_low));
  // Prints counts and verdict, then stops
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      num_errors++;
      end_sim();
    end
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask
  task automatic clr();
    apb(1'b1, `CFR_OFS_STATUS, 32'hF);
  endtask
  initial begin
    repeat (100000) @(posedge ref_clk);
    num_errors++;
    end_sim();
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    // Reset values and read-write access of the timing registers
    for (int i = 0; i < 9; i++) begin
      rd_chk(`CFR_OFS_STPRD + 12'(4 * i), {24'h0, rstv[i]});
      apb(1'b1, `CFR_OFS_STPRD + 12'(4 * i), 32'h5C);
      rd_chk(`CFR_OFS_STPRD + 12'(4 * i), 32'h5C);
      apb(1'b1, `CFR_OFS_STPRD + 12'(4 * i), {24'h0, rstv[i]});
    end
    rd_chk(`CFR_OFS_CTRL, 32'h0);
    rd_chk(12'h030, 32'h0);
    check(32'(slv), 32'h1);
    // Frame with acknowledge zero, all flag interrupts enabled
    apb(1'b1, `CFR_OFS_CTRL, 32'h3C);
    cfr_initiator_inst.start();
    rd_chk(`CFR_OFS_STATUS, 32'h1);
    check(32'(irq), 32'h1);
    cfr_initiator_inst.send_byte(8'hA5, 1'b1, 0);
    check(32'(cfr_initiator_inst.seen), 32'h0);
    check(32'(cec_out), 32'h0);
    cfr_initiator_inst.wait_e(4);
    rd_chk(`CFR_OFS_RXDATA, 32'h1A5);
    rd_chk(`CFR_OFS_STATUS, 32'h3);
    check(32'(irq), 32'h1);
    apb(1'b1, `CFR_OFS_RXDATA, 32'h0);
    rd_chk(`CFR_OFS_RXDATA, 32'h1A5);
    clr();
    rd_chk(`CFR_OFS_STATUS, 32'h0);
    check(32'(irq), 32'h0);
    // Acknowledge one, only the timeout interrupt enabled
    apb(1'b1, `CFR_OFS_CTRL, 32'h22);
    cfr_initiator_inst.start();
    // Long idle before the tenth edge must not count as a timeout
    cfr_initiator_inst.send_byte(8'h3C, 1'b0, 100);
    check(32'(cfr_initiator_inst.seen), 32'h1);
    cfr_initiator_inst.wait_e(4);
    rd_chk(`CFR_OFS_RXDATA, 32'h03C);
    rd_chk(`CFR_OFS_STATUS, 32'h3);
    check(32'(irq), 32'h0);
    clr();
    // Next byte stops after one bit, so the edge wait runs out
    cfr_initiator_inst.send_bit(1'b1);
    cfr_initiator_inst.wait_e(120);
    rd_chk(`CFR_OFS_STATUS, 32'h8);
    check(32'(irq), 32'h1);
    clr();
    // Two falls six periods apart after a start
    apb(1'b1, `CFR_OFS_CTRL, 32'h12);
    cfr_initiator_inst.start();
    cfr_initiator_inst.slot(2, 6);
    cfr_initiator_inst.slot(2, 130);
    rd_chk(`CFR_OFS_STATUS, 32'h5);
    check(32'(irq), 32'h1);
    clr();
    // Transmitter role ignores a start
    apb(1'b1, `CFR_OFS_CTRL, 32'h05);
    cfr_initiator_inst.start();
    rd_chk(`CFR_OFS_STATUS, 32'h0);
    // Wake needs both enables and a low bus during stop
    stop_mode <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, `CFR_OFS_CTRL, k == 0 ? 32'hC1 : 32'h41);
      fork
        cfr_initiator_inst.slot(10, 20);
        begin
          repeat (20) @(posedge ref_clk);
          check(32'(osc_wake), k == 0 ? 32'h1 : 32'h0);
        end
      join
    end
    end_sim();
  end
endmodule
